// ===== rtl/irq_regs.vh
// register map, field positions, reset values and timing counts
`ifndef IRQ_REGS_VH
`define IRQ_REGS_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define NODE_COUNT 112
`define CHAN_COUNT 8

// ----------------------------------------------------------------
// byte offsets; channel base in address bits 11:7, channel registers in bits 3:2
// ----------------------------------------------------------------
`define OFF_NODE_LAST 12'h1BC
`define OFF_CHAN_BASE 5'h04
`define OFF_CH_SRC 2'h0
`define OFF_CH_DST 2'h1
`define OFF_CH_CNT 2'h2
`define OFF_CH_CTL 2'h3
`define OFF_TRAP_FLAG 12'h300
`define OFF_SRC_SEL 12'h304
`define OFF_XMODE 12'h308
`define OFF_XPAT 12'h30C
`define OFF_SYS_CTL 12'h310
`define OFF_SW_TRAP 12'h314
`define OFF_STATUS 12'h318

// ----------------------------------------------------------------
// node control fields
// ----------------------------------------------------------------
`define F_PRIO 3:0
`define F_EN 4
`define F_XFER 5
`define F_CHAN 8:6
`define F_REQ 15

// ----------------------------------------------------------------
// channel control and system control fields
// ----------------------------------------------------------------
`define C_WORD 0
`define C_INCS 1
`define C_INCD 2
`define C_CONT 3
`define S_JCACHE 0
`define S_SYSREQ0 1
`define S_SYSREQ1 2

// ----------------------------------------------------------------
// reset values, vectors, timing
// ----------------------------------------------------------------
`define RST_NODE 9'h000
`define RST_SYS 3'h0
`define VEC_NODE 8'h10
`define RESP_FAST 4'h7
`define RESP_SLOW 4'hB
`define RESP_PIPE 4'h3

`endif

// ===== rtl/edge_trigger_logic.v
// one input channel: two-flop synchroniser and edge event detection
`timescale 1ns/10ps
module edge_trigger_logic (
  input wire clk, // system clock
  input wire reset, // async reset, active high
  input wire pin, // asynchronous input
  input wire rise_en, // detect rising edges
  input wire fall_en, // detect falling edges
  output reg level, // synchronised level
  output reg event_pulse // one-cycle event
);
  reg sync1;
  reg prev;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1 <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      sync1 <= pin;
      level <= sync1;
      prev <= level;
      event_pulse <= (level & ~prev & rise_en) |
        (~level & prev & fall_en);
    end
  end
endmodule

// ===== rtl/interrupt_and_event_transfer.v
// interrupt nodes, event transfer channels, external requests and traps
`timescale 1ns/10ps
`include "irq_regs.vh"
module interrupt_and_event_transfer (
  input wire clk, // 250 MHz system clock
  input wire reset, // async reset, active high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write
  input wire [11:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte lanes
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  input wire [111:0] irq_src, // peripheral request pulses
  input wire [5:0] hw_trap, // hardware trap pulses
  input wire [3:0] ext_req_pin, // external request pins
  input wire [2:0] service_request_pin, // service request pins
  input wire vector_ack, // cpu took the vector
  input wire trap_return, // cpu left trap service
  output reg vector_req, // branch request to cpu
  output reg [7:0] vector_num, // vector table entry
  output reg xfer_valid, // one stolen transfer cycle
  output reg [15:0] xfer_src, // transfer source address
  output reg [15:0] xfer_dst, // transfer destination address
  output reg xfer_word // word (1) or byte (0)
);
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_REQ = 2'b10;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [15:0] wr16;
    input [15:0] old;
    input [15:0] dat;
    input [1:0] sel;
    begin
      wr16[7:0] = sel[0] ? dat[7:0] : old[7:0];
      wr16[15:8] = sel[1] ? dat[15:8] : old[15:8];
    end
  endfunction

  function pick_src;
    input [1:0] sel;
    input own;
    input [3:0] gated;
    begin
      if (sel == 2'h0) begin
        pick_src = own;
      end else begin
        pick_src = gated[sel - 2'h1];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [8:0] node_cfg [0:111];
  reg [111:0] node_request_flag;
  reg [15:0] ch_src [0:7];
  reg [15:0] ch_dst [0:7];
  reg [7:0] ch_cnt [0:7];
  reg [3:0] ch_ctl [0:7];
  reg [7:0] trap_flag_register;
  reg [7:0] trap_pend;
  reg [3:0] trap_level;
  reg [7:0] node_source_select;
  reg [15:0] xmode;
  reg [31:0] xpat;
  reg [2:0] sys_ctl;
  reg sw_pend;
  reg [7:0] sw_num;
  reg [1:0] state;
  reg [3:0] lat_cnt;
  integer ri;
  integer ai;
  integer ti;

  // ----------------------------------------------------------------
  // external request unit
  // ----------------------------------------------------------------
  wire [3:0] ext_lvl;
  wire [3:0] ext_ev;
  wire [3:0] gate_out;
  wire [2:0] srp_ev;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_ext
      reg gated;
      wire [3:0] mask = xpat[4*k+3:4*k];
      wire [3:0] pat = xpat[4*k+19:4*k+16];
      wire [1:0] gmode = xmode[2*k+9:2*k+8];
      wire hit = ((ext_lvl & mask) == (pat & mask));
      edge_trigger_logic u_edge_trigger_logic (
        .clk(clk),
        .reset(reset),
        .pin(ext_req_pin[k]),
        .rise_en(xmode[2*k]),
        .fall_en(xmode[2*k+1]),
        .level(ext_lvl[k]),
        .event_pulse(ext_ev[k])
      );
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          gated <= 1'b0;
        end else begin
          gated <= (|(ext_ev & mask)) & ((gmode == 2'h1) |
            ((gmode == 2'h2) & hit) | ((gmode == 2'h3) & ~hit));
        end
      end
      assign gate_out[k] = gated;
    end
    for (k = 0; k < 3; k = k + 1) begin : g_srp
      edge_trigger_logic u_srp (
        .clk(clk),
        .reset(reset),
        .pin(service_request_pin[k]),
        .rise_en(1'b1),
        .fall_en(1'b0),
        .level(),
        .event_pulse(srp_ev[k])
      );
    end
  endgenerate

  wire system_request_zero = srp_ev[0] & sys_ctl[`S_SYSREQ0];
  wire system_request_one = (srp_ev[1] | srp_ev[2]) &
    sys_ctl[`S_SYSREQ1];
  wire [7:0] trap_set = {hw_trap, system_request_one, system_request_zero};

  // ----------------------------------------------------------------
  // node sources
  // ----------------------------------------------------------------
  wire [111:0] hw_set;
  assign hw_set[107:0] = irq_src[107:0];
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_share
      assign hw_set[108+k] = pick_src(node_source_select[2*k+1:2*k],
        irq_src[108+k], gate_out);
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  reg [3:0] best_p;
  reg [6:0] best_i;
  reg [2:0] t_idx;
  reg t_any;
  always @* begin
    best_p = 4'h0;
    best_i = 7'h00;
    for (ai = 0; ai < `NODE_COUNT; ai = ai + 1) begin
      if (node_request_flag[ai] && node_cfg[ai][`F_EN] &&
          node_cfg[ai][`F_PRIO] > best_p) begin
        best_p = node_cfg[ai][`F_PRIO];
        best_i = ai[6:0];
      end
    end
    t_any = 1'b0;
    t_idx = 3'h0;
    for (ti = 0; ti < 8; ti = ti + 1) begin
      if (trap_pend[ti]) begin
        t_any = 1'b1;
        t_idx = ti[2:0];
      end
    end
  end

  wire [8:0] win_cfg = node_cfg[best_i];
  wire [2:0] wc = win_cfg[`F_CHAN];
  wire [3:0] wctl = ch_ctl[wc];
  wire [7:0] step_s = (wctl[`C_WORD] ? 8'h02 : 8'h01);
  wire t_take = t_any & (({1'b0, t_idx} + 4'h1) > trap_level);
  wire idle = (state == ST_IDLE);
  wire take_trap = idle & t_take;
  wire take_sw = idle & ~t_take & sw_pend;
  wire take_node = idle & ~t_take & ~sw_pend & (trap_level == 4'h0) &
    (best_p != 4'h0);
  wire do_xfer = win_cfg[`F_XFER] &
    ((ch_cnt[wc] != 8'h00) | wctl[`C_CONT]);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr = bus_req & wb_ack_o & wb_we_i;
  wire is_node = (wb_adr_i <= `OFF_NODE_LAST);
  wire [6:0] nidx = wb_adr_i[8:2];
  wire is_chan = (wb_adr_i[11:7] == `OFF_CHAN_BASE);
  wire [2:0] cidx = wb_adr_i[6:4];
  wire [1:0] creg = wb_adr_i[3:2];

  reg [111:0] next_req;
  reg [7:0] next_tf;
  always @* begin
    next_req = node_request_flag;
    if (take_node) begin
      next_req[best_i] = 1'b0;
    end
    if (wr && is_node && wb_sel_i[1]) begin
      next_req[nidx] = wb_dat_i[`F_REQ];
    end
    next_req = next_req | hw_set;
    next_tf = trap_flag_register;
    if (wr && wb_adr_i == `OFF_TRAP_FLAG && wb_sel_i[0]) begin
      next_tf = next_tf & ~wb_dat_i[7:0];
    end
    next_tf = next_tf | trap_set;
  end

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (is_node) begin
      rd_next = {16'h0000, node_request_flag[nidx], 4'h0,
        node_cfg[nidx][`F_CHAN], 2'h0, node_cfg[nidx][5:0]};
    end else if (is_chan) begin
      if (creg == `OFF_CH_SRC) begin
        rd_next = {16'h0000, ch_src[cidx]};
      end else if (creg == `OFF_CH_DST) begin
        rd_next = {16'h0000, ch_dst[cidx]};
      end else if (creg == `OFF_CH_CNT) begin
        rd_next = {24'h000000, ch_cnt[cidx]};
      end else begin
        rd_next = {28'h0000000, ch_ctl[cidx]};
      end
    end else if (wb_adr_i == `OFF_TRAP_FLAG) begin
      rd_next = {24'h000000, trap_flag_register};
    end else if (wb_adr_i == `OFF_SRC_SEL) begin
      rd_next = {24'h000000, node_source_select};
    end else if (wb_adr_i == `OFF_XMODE) begin
      rd_next = {12'h000, ext_lvl, xmode};
    end else if (wb_adr_i == `OFF_XPAT) begin
      rd_next = xpat;
    end else if (wb_adr_i == `OFF_SYS_CTL) begin
      rd_next = {29'h00000000, sys_ctl};
    end else if (wb_adr_i == `OFF_SW_TRAP) begin
      rd_next = {23'h000000, sw_pend, sw_num};
    end else if (wb_adr_i == `OFF_STATUS) begin
      rd_next = {18'h00000, trap_pend, trap_level, state};
    end
  end

  // ----------------------------------------------------------------
  // registers and sequencing
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (ri = 0; ri < `NODE_COUNT; ri = ri + 1) begin
        node_cfg[ri] <= `RST_NODE;
      end
      for (ri = 0; ri < `CHAN_COUNT; ri = ri + 1) begin
        ch_src[ri] <= 16'h0000;
        ch_dst[ri] <= 16'h0000;
        ch_cnt[ri] <= 8'h00;
        ch_ctl[ri] <= 4'h0;
      end
      node_request_flag <= 112'h0;
      trap_flag_register <= 8'h00;
      trap_pend <= 8'h00;
      trap_level <= 4'h0;
      node_source_select <= 8'h00;
      xmode <= 16'h0000;
      xpat <= 32'h00000000;
      sys_ctl <= `RST_SYS;
      sw_pend <= 1'b0;
      sw_num <= 8'h00;
      state <= ST_IDLE;
      lat_cnt <= 4'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      vector_req <= 1'b0;
      vector_num <= 8'h00;
      xfer_valid <= 1'b0;
      xfer_src <= 16'h0000;
      xfer_dst <= 16'h0000;
      xfer_word <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_next;
      end
      node_request_flag <= next_req;
      trap_flag_register <= next_tf;
      trap_pend <= (trap_pend & ~({7'h00, take_trap} << t_idx)) |
        trap_set;
      if (wr && is_node && wb_sel_i[0]) begin
        node_cfg[nidx][5:0] <= wb_dat_i[5:0];
      end
      if (wr && is_node && wb_sel_i[1]) begin
        node_cfg[nidx][`F_CHAN] <= wb_dat_i[10:8];
      end
      if (wr && is_chan) begin
        if (creg == `OFF_CH_SRC) begin
          ch_src[cidx] <= wr16(ch_src[cidx], wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (creg == `OFF_CH_DST) begin
          ch_dst[cidx] <= wr16(ch_dst[cidx], wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (creg == `OFF_CH_CNT && wb_sel_i[0]) begin
          ch_cnt[cidx] <= wb_dat_i[7:0];
        end else if (creg == `OFF_CH_CTL && wb_sel_i[0]) begin
          ch_ctl[cidx] <= wb_dat_i[3:0];
        end
      end
      if (wr && wb_adr_i == `OFF_SRC_SEL && wb_sel_i[0]) begin
        node_source_select <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `OFF_XMODE) begin
        xmode <= wr16(xmode, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr && wb_adr_i == `OFF_XPAT) begin
        xpat[15:0] <= wr16(xpat[15:0], wb_dat_i[15:0], wb_sel_i[1:0]);
        xpat[31:16] <= wr16(xpat[31:16], wb_dat_i[31:16], wb_sel_i[3:2]);
      end
      if (wr && wb_adr_i == `OFF_SYS_CTL && wb_sel_i[0]) begin
        sys_ctl <= wb_dat_i[2:0];
      end
      // a new software trap written while one is taken is kept
      if (wr && wb_adr_i == `OFF_SW_TRAP && wb_sel_i[0]) begin
        sw_pend <= 1'b1;
        sw_num <= wb_dat_i[7:0];
      end else if (take_sw) begin
        sw_pend <= 1'b0;
      end
      if (take_trap) begin
        trap_level <= {1'b0, t_idx} + 4'h1;
      end else if (trap_return) begin
        trap_level <= 4'h0;
      end
      xfer_valid <= 1'b0;
      if (take_node && do_xfer) begin
        xfer_valid <= 1'b1;
        xfer_src <= ch_src[wc];
        xfer_dst <= ch_dst[wc];
        xfer_word <= wctl[`C_WORD];
        if (wctl[`C_INCS]) begin
          ch_src[wc] <= ch_src[wc] + {8'h00, step_s};
        end
        if (wctl[`C_INCD]) begin
          ch_dst[wc] <= ch_dst[wc] + {8'h00, step_s};
        end
        if (!wctl[`C_CONT]) begin
          ch_cnt[wc] <= ch_cnt[wc] - 8'h01;
        end
      end
      case (state)
        ST_IDLE: begin
          if (take_trap) begin
            vector_req <= 1'b1;
            vector_num <= {5'h00, t_idx};
            state <= ST_REQ;
          end else if (take_sw) begin
            vector_req <= 1'b1;
            vector_num <= sw_num;
            state <= ST_REQ;
          end else if (take_node && !do_xfer) begin
            vector_num <= `VEC_NODE + {1'b0, best_i};
            lat_cnt <= (sys_ctl[`S_JCACHE] ? `RESP_FAST : `RESP_SLOW) -
              `RESP_PIPE;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (lat_cnt == 4'h0) begin
            vector_req <= 1'b1;
            state <= ST_REQ;
          end else begin
            lat_cnt <= lat_cnt - 4'h1;
          end
        end
        ST_REQ: begin
          if (vector_ack) begin
            vector_req <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== testbench/irq_checker_asserts.sv
// concurrent checks on the interrupt and event transfer block ports
`timescale 1ns/10ps
module irq_checker (
  input wire clk, // system clock
  input wire reset, // async reset, active high
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // bus strobe
  input wire wb_ack_o, // bus acknowledge
  input wire [5:0] hw_trap, // hardware trap pulses
  input wire vector_req, // branch request
  input wire [7:0] vector_num, // vector entry
  input wire vector_ack, // cpu took vector
  input wire trap_return, // cpu left trap
  input wire xfer_valid // stolen transfer cycle
);
  logic in_trap;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // trap service tracking
  // ------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset)
      in_trap <= 1'b0;
    else if (trap_return)
      in_trap <= 1'b0;
    else if (vector_req && vector_ack && vector_num < 8'h08)
      in_trap <= 1'b1;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not acked next cycle");
  chk_ack_has_cause: assert property (wb_ack_o |->
    $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_vector_holds: assert property (vector_req && !vector_ack |=>
    vector_req && $stable(vector_num)) else $error("vector dropped early");
  chk_vector_drop: assert property (vector_req && vector_ack |=>
    !vector_req) else $error("vector held after ack");
  chk_trap_fast: assert property (hw_trap != 6'h00 && !in_trap
    && !vector_req |-> ##2 vector_req)
    else $error("trap not raised in two cycles");
  chk_trap_no_xfer: assert property (in_trap && $past(in_trap, 2)
    |-> !xfer_valid) else $error("transfer during trap service");
  chk_reset_quiet: assert property ($fell(reset) |->
    !vector_req && !xfer_valid && !wb_ack_o) else $error("busy after reset");
  cover property (xfer_valid);
  cover property (vector_req && vector_ack && vector_num < 8'h08);
  cover property (trap_return);
endmodule
bind interrupt_and_event_transfer irq_checker irq_checker_inst (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .hw_trap(hw_trap), .vector_req(vector_req),
  .vector_num(vector_num), .vector_ack(vector_ack),
  .trap_return(trap_return), .xfer_valid(xfer_valid));

// ===== testbench/cpu_core_model.sv
// cpu side: takes vectors promptly or slowly, leaves trap services later
`timescale 1ns/10ps
module cpu_core_model (
  input wire clk, // system clock
  input wire reset, // async reset, active high
  input wire vector_req, // branch request
  input wire [7:0] vector_num, // vector entry
  output logic vector_ack, // vector taken
  output logic trap_return // leave trap service
);
  logic slow;
  int wait_n;
  int ret_n;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      vector_ack <= 1'b0;
      trap_return <= 1'b0;
      slow <= 1'b0;
      wait_n <= 0;
      ret_n <= 0;
    end else begin
      trap_return <= (ret_n == 1);
      if (ret_n != 0)
        ret_n <= ret_n - 1;
      if (vector_ack && vector_req) begin
        vector_ack <= 1'b0;
        slow <= ~slow;
        // trap routines run a while before returning
        if (vector_num < 8'h08)
          ret_n <= 30;
      end else if (vector_req && !vector_ack) begin
        if (wait_n >= (slow ? 3 : 0)) begin
          vector_ack <= 1'b1;
          wait_n <= 0;
        end else
          wait_n <= wait_n + 1;
      end
    end
  end
endmodule

// ===== testbench/test_interrupt_and_event_transfer.sv
// self-checking bench for the interrupt and event transfer block
`timescale 1ns/10ps
module test_interrupt_and_event_transfer;
  typedef struct { int node; logic jc; int lat; } row_t;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic [111:0] irq_src = '0;
  logic [5:0] hw_trap = 6'h00;
  logic [2:0] service_request_pin = 3'h0;
  logic [3:0] ext_req_pin = 4'h0;
  logic wb_ack_o, vector_ack, trap_return, vector_req, xfer_valid, xfer_word;
  logic [7:0] vector_num;
  logic [15:0] xfer_src, xfer_dst;
  int mismatches = 0, check_count = 0, cycles = 0, lat;
  row_t rows [4] = '{'{0, 1'b1, 7}, '{5, 1'b0, 11}, '{107, 1'b1, 7},
    '{111, 1'b1, 7}};
  interrupt_and_event_transfer interrupt_and_event_transfer_inst (
    .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_src(irq_src),
    .hw_trap(hw_trap), .ext_req_pin(ext_req_pin),
    .service_request_pin(service_request_pin), .vector_ack(vector_ack),
    .trap_return(trap_return), .vector_req(vector_req),
    .vector_num(vector_num), .xfer_valid(xfer_valid),
    .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_word(xfer_word));
  cpu_core_model cpu_core_model_inst (.clk(clk), .reset(reset),
    .vector_req(vector_req), .vector_num(vector_num),
    .vector_ack(vector_ack), .trap_return(trap_return));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge clk);
    // hold the request until the edge that samples ack high
    while (wb_ack_o !== 1'b1)
      @(posedge clk);
    rdat = wb_dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  // pulse requests, count cycles until a vector or a transfer shows
  task fire(input logic [111:0] irq, input logic [5:0] trap);
    @(posedge clk);
    irq_src <= irq;
    hw_trap <= trap;
    lat = 0;
    @(negedge clk);
    while (vector_req !== 1'b1 && xfer_valid !== 1'b1 && lat < 80) begin
      @(posedge clk);
      irq_src <= '0;
      hw_trap <= 6'h00;
      @(negedge clk);
      lat++;
    end
  endtask
  task settle;
    while (vector_req !== 1'b0)
      @(negedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, 12'h000, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, 12'hFFC, 32'h0);
    check(rdat, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wb(1'b1, 12'h310, {31'h0, rows[i].jc});
      wb(1'b1, 12'(rows[i].node * 4), 32'h13);
      fire(112'h1 << rows[i].node, 6'h00);
      check(lat, rows[i].lat);
      check(vector_num, 8'h10 + rows[i].node);
      settle();
      wb(1'b0, 12'(rows[i].node * 4), 32'h0);
      check(rdat[15], 1'b0);
    end
    $display("test node rows done");
    wb(1'b1, 12'h008, 32'h15);
    wb(1'b1, 12'h00C, 32'h19);
    fire((112'h1 << 2) | (112'h1 << 3), 6'h00);
    check(vector_num, 8'h13);
    settle();
    fire('0, 6'h00);
    check(vector_num, 8'h12);
    settle();
    wb(1'b1, 12'h010, 32'h8013);
    fire('0, 6'h00);
    check(vector_num, 8'h14);
    settle();
    $display("test priority done");
    wb(1'b1, 12'h200, 32'h1000);
    wb(1'b1, 12'h204, 32'h2000);
    wb(1'b1, 12'h208, 32'h2);
    wb(1'b1, 12'h20C, 32'h7);
    wb(1'b1, 12'h018, 32'h33);
    for (int j = 0; j < 3; j++) begin
      fire(112'h1 << 6, 6'h00);
      if (j < 2) begin
        check(lat, 2);
        check(xfer_src, 16'h1000 + 2 * j);
        check(xfer_dst, 16'h2000 + 2 * j);
        check(xfer_word, 1'b1);
      end else
        check(vector_num, 8'h16);
      settle();
    end
    wb(1'b1, 12'h20C, 32'hF);
    fire(112'h1 << 6, 6'h00);
    check(xfer_valid, 1'b1);
    wb(1'b0, 12'h208, 32'h0);
    check(rdat[7:0], 8'h00);
    // byte transfer on the last channel, source pointer only
    wb(1'b1, 12'h270, 32'h40);
    wb(1'b1, 12'h278, 32'h1);
    wb(1'b1, 12'h27C, 32'h2);
    wb(1'b1, 12'h018, 32'h733);
    fire(112'h1 << 6, 6'h00);
    check(xfer_src, 16'h0040);
    check(xfer_word, 1'b0);
    wb(1'b0, 12'h270, 32'h0);
    check(rdat[15:0], 16'h0041);
    wb(1'b0, 12'h278, 32'h0);
    check(rdat[7:0], 8'h00);
    $display("test transfer done");
    // input 0 through gate 0 onto shared node 108
    wb(1'b1, 12'h308, 32'h0101);
    wb(1'b1, 12'h30C, 32'h1);
    wb(1'b1, 12'h304, 32'h1);
    wb(1'b1, 12'h1B0, 32'h13);
    @(posedge clk);
    ext_req_pin <= 4'h1;
    fire('0, 6'h00);
    check(vector_num, 8'h7C);
    settle();
    wb(1'b1, 12'h308, 32'h0302);
    wb(1'b1, 12'h30C, 32'h10001);
    @(posedge clk);
    ext_req_pin <= 4'h0;
    fire('0, 6'h00);
    check(vector_num, 8'h7C);
    settle();
    wb(1'b1, 12'h308, 32'h0201);
    wb(1'b1, 12'h30C, 32'h1);
    @(posedge clk);
    ext_req_pin <= 4'h1;
    fire('0, 6'h00);
    check(lat, 80);
    wb(1'b0, 12'h308, 32'h0);
    check(rdat[19:16], 4'h1);
    $display("test external requests done");
    fire('0, 6'h02);
    check(lat, 2);
    check(vector_num, 8'h03);
    settle();
    wb(1'b0, 12'h300, 32'h0);
    check(rdat[3], 1'b1);
    fire(112'h1, 6'h00);
    check(lat > 11, 1'b1);
    settle();
    wb(1'b1, 12'h310, 32'h3);
    @(posedge clk);
    service_request_pin <= 3'h1;
    fire('0, 6'h00);
    check(vector_num, 8'h00);
    settle();
    wb(1'b0, 12'h300, 32'h0);
    check(rdat[0], 1'b1);
    wb(1'b1, 12'h314, 32'h2A);
    fire('0, 6'h00);
    check(vector_num, 8'h2A);
    settle();
    $display("test traps done");
    // reset in mid-run clears flags and configuration
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, 12'h300, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, 12'h018, 32'h0);
    check(rdat, 32'h0);
    $display("test reset mid-run done");
    give_verdict();
  end
endmodule
